// ===== rtl/dac_serial_load_port_map.svh
// Purpose: constants of the three-wire converter load port
// Assumes: i_clk at 50 MHz, serial clock sampled as a plain input
// Notes:   word layout, reset values and timing follow
`ifndef DAC_SERIAL_LOAD_PORT_MAP_SVH
`define DAC_SERIAL_LOAD_PORT_MAP_SVH

// ============================================================
// word layout
`define DSLP_WORD_BITS  16
`define DSLP_CNT_BITS   5
`define DSLP_CMD_MSB    15
`define DSLP_CMD_LSB    13
`define DSLP_CODE_MSB   12
`define DSLP_CODE_LSB   1
`define DSLP_SUB_POS    0

// ============================================================
// reset values
`define DSLP_CODE_RESET 12'h000
`define DSLP_WORD_RESET 16'h0000
`define DSLP_CNT_RESET  5'h00
// converter code zero seen with its msb turned over
`define DSLP_BIP_RESET  12'h800

// ============================================================
// timing
`define DSLP_CLK_HZ       50000000
`define DSLP_SCLK_MAX_HZ  10000000
`define DSLP_MIN_SAMPLES  4

`endif

// ===== rtl/dac_serial_load_port_pkg.sv
// Purpose: types of the three-wire converter load port
// Assumes: constants live in dac_serial_load_port_map.svh
// Notes:   nothing here is imported; users write the package name
package dac_serial_load_port_pkg;

	// ============================================================
	// receive state, one-hot
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_SHIFT = 2'b10
	} state_t;

	typedef logic [11:0] code_t;

endpackage

// ===== rtl/pin_synchronizer.sv
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: pins are asynchronous to i_clk
// Notes:   first stage is read by the second stage only
module pin_synchronizer #(
	parameter int          WIDTH     = 3,
	parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
	// clock, reset, enable
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic             i_ce,
	// pins and synchronised levels
	input  wire logic [WIDTH-1:0] i_pin,
	output logic      [WIDTH-1:0] o_level
);

	// ============================================================
	// per-bit two-stage chain
	genvar b;
	generate
		if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
			$error("pin_synchronizer width out of range");
		end
		for (b = 0; b < WIDTH; b++) begin : g_bit
			logic meta_reg;
			logic meta_next;
			logic level_reg;
			logic level_next;
			always_comb begin
				meta_next  = i_pin[b];
				level_next = meta_reg;
			end
			always_ff @(posedge i_clk) begin
				if (i_reset) begin
					meta_reg  <= RESET_VAL[b];
					level_reg <= RESET_VAL[b];
				end else if (i_ce) begin
					meta_reg  <= meta_next;
					level_reg <= level_next;
				end
			end
			assign o_level[b] = level_reg;
		end
	endgenerate

endmodule // pin_synchronizer

// ===== rtl/dac_serial_load_port.sv
// Purpose: serial write port and double-buffered code registers
// Assumes: select, serial clock and data are pins, sampled by i_clk
// Notes:   serial clock must be several i_clk periods per half cycle
`include "dac_serial_load_port_map.svh"

module dac_serial_load_port #(
	parameter int CLK_HZ  = `DSLP_CLK_HZ,
	parameter int SCLK_HZ = `DSLP_SCLK_MAX_HZ
) (
	// clock, reset, enable
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_ce,
	// serial pins
	input  wire logic        i_select_n,
	input  wire logic        i_sclk,
	input  wire logic        i_sdata,
	// register contents and state
	output logic      [11:0] o_input_code,
	output logic      [11:0] o_unipolar_code,
	output logic      [11:0] o_bipolar_code,
	output logic             o_shutdown,
	output logic             o_word_taken
);

	// ============================================================
	// elaboration checks
	generate
		if (CLK_HZ < `DSLP_MIN_SAMPLES * SCLK_HZ) begin : g_bad_rate
			$error("i_clk too slow to sample the serial clock");
		end
	endgenerate

	// ============================================================
	// pin synchronisation
	logic [2:0] pin_level;
	logic       sel_lvl;
	logic       sclk_lvl;
	logic       din_lvl;

	pin_synchronizer #(
		.WIDTH     (3),
		.RESET_VAL (32'h0000_0006)
	) u_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_ce    (i_ce),
		.i_pin   ({i_select_n, i_sclk, i_sdata}),
		.o_level (pin_level)
	);

	assign sel_lvl  = pin_level[2];
	assign sclk_lvl = pin_level[1];
	assign din_lvl  = pin_level[0];

	// ============================================================
	// edge detection
	logic sclk_prev_reg;
	logic sclk_prev_next;
	logic sel_prev_reg;
	logic sel_prev_next;
	logic sclk_rise;
	logic sel_rise;

	always_comb begin
		sclk_prev_next = sclk_lvl;
		sel_prev_next  = sel_lvl;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sclk_prev_reg <= 1'b1;
			sel_prev_reg  <= 1'b1;
		end else if (i_ce) begin
			sclk_prev_reg <= sclk_prev_next;
			sel_prev_reg  <= sel_prev_next;
		end
	end

	assign sclk_rise = sclk_lvl & ~sclk_prev_reg;
	assign sel_rise  = sel_lvl & ~sel_prev_reg;

	// ============================================================
	// shifter
	dac_serial_load_port_pkg::state_t state_reg;
	dac_serial_load_port_pkg::state_t state_next;
	logic [`DSLP_WORD_BITS-1:0] shift_reg;
	logic [`DSLP_WORD_BITS-1:0] shift_next;
	logic [`DSLP_CNT_BITS-1:0]  count_reg;
	logic [`DSLP_CNT_BITS-1:0]  count_next;
	logic                       word_done;
	logic                       word_short;
	logic                       shift_en;

	// the count saturates: extra edges keep only the last sixteen bits
	localparam logic [`DSLP_CNT_BITS-1:0] FULL_CNT =
		`DSLP_CNT_BITS'(`DSLP_WORD_BITS);

	assign shift_en   = ~sel_lvl & sclk_rise;
	assign word_done  = (state_reg == dac_serial_load_port_pkg::ST_SHIFT) &&
		sel_rise && (count_reg == FULL_CNT);
	assign word_short = (state_reg == dac_serial_load_port_pkg::ST_SHIFT) &&
		sel_rise && (count_reg != FULL_CNT);

	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		count_next = count_reg;
		unique case (state_reg)
			dac_serial_load_port_pkg::ST_IDLE: begin
				count_next = `DSLP_CNT_RESET;
				if (!sel_lvl) begin
					state_next = dac_serial_load_port_pkg::ST_SHIFT;
				end
			end
			dac_serial_load_port_pkg::ST_SHIFT: begin
				if (sel_lvl) begin
					state_next = dac_serial_load_port_pkg::ST_IDLE;
				end
			end
			// two of the four codes are not one-hot: fall back to idle
			default: begin
				state_next = dac_serial_load_port_pkg::ST_IDLE;
			end
		endcase
		if (shift_en) begin
			// msb arrives first and ends up at the top
			shift_next = {shift_reg[`DSLP_WORD_BITS-2:0], din_lvl};
			if (state_reg == dac_serial_load_port_pkg::ST_IDLE) begin
				count_next = `DSLP_CNT_BITS'(1);
			end else if (count_reg != FULL_CNT) begin
				count_next = count_reg + `DSLP_CNT_BITS'(1);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_reg <= dac_serial_load_port_pkg::ST_IDLE;
			shift_reg <= `DSLP_WORD_RESET;
			count_reg <= `DSLP_CNT_RESET;
		end else if (i_ce) begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			count_reg <= count_next;
		end
	end

	// ============================================================
	// command decode and code registers
	logic [2:0]  cmd;
	logic [11:0] code;
	dac_serial_load_port_pkg::code_t input_reg;
	dac_serial_load_port_pkg::code_t input_next;
	dac_serial_load_port_pkg::code_t conv_reg;
	dac_serial_load_port_pkg::code_t conv_next;
	dac_serial_load_port_pkg::code_t bip_reg;
	dac_serial_load_port_pkg::code_t bip_next;
	logic shutdown_reg;
	logic shutdown_next;
	logic taken_reg;
	logic taken_next;

	assign cmd  = shift_reg[`DSLP_CMD_MSB:`DSLP_CMD_LSB];
	// sub-bit is dropped: the converter always sees it as zero
	assign code = shift_reg[`DSLP_CODE_MSB:`DSLP_CODE_LSB];

	always_comb begin
		input_next    = input_reg;
		conv_next     = conv_reg;
		shutdown_next = shutdown_reg;
		taken_next    = word_done;
		if (word_done) begin
			unique case (cmd[1:0])
				2'h0: begin
					input_next    = code;
					conv_next     = code;
					shutdown_next = 1'b0;
				end
				2'h1: begin
					input_next = code;
				end
				2'h2: begin
					conv_next     = input_reg;
					shutdown_next = 1'b0;
				end
				2'h3: begin
					// shutdown leaves the input register alone for recall
					if (cmd[2]) begin
						shutdown_next = 1'b1;
					end
				end
			endcase
		end
		bip_next = {~conv_next[11], conv_next[10:0]};
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			input_reg    <= `DSLP_CODE_RESET;
			conv_reg     <= `DSLP_CODE_RESET;
			bip_reg      <= `DSLP_BIP_RESET;
			shutdown_reg <= 1'b0;
			taken_reg    <= 1'b0;
		end else if (i_ce) begin
			input_reg    <= input_next;
			conv_reg     <= conv_next;
			bip_reg      <= bip_next;
			shutdown_reg <= shutdown_next;
			taken_reg    <= taken_next;
		end
	end

	assign o_input_code    = input_reg;
	assign o_unipolar_code = conv_reg;
	assign o_bipolar_code  = bip_reg;
	assign o_shutdown      = shutdown_reg;
	assign o_word_taken    = taken_reg;

	// ============================================================
	// assertions
	idle_ignore_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && sel_lvl) |=> $stable(shift_reg))
		else $error("shifter moved while select high");

	bit_capture_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && shift_en) |=> shift_reg[0] == $past(din_lvl))
		else $error("data bit not captured on clock rise");

	msb_first_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && shift_en) |=>
		shift_reg[15:1] == $past(shift_reg[14:0]))
		else $error("shift direction wrong");

	load_both_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && word_done && cmd[1:0] == 2'h0) |=>
		(conv_reg == $past(code)) && (input_reg == $past(code)) &&
		!o_shutdown && o_word_taken)
		else $error("load of both registers failed");

	copy_input_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && word_done && cmd[1:0] == 2'h2) |=>
		(conv_reg == $past(input_reg)) && !o_shutdown)
		else $error("copy to converter register failed");

	shutdown_keep_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && word_done && cmd == 3'h7) |=>
		o_shutdown && $stable(input_reg) && $stable(conv_reg))
		else $error("shutdown lost register contents");

	short_word_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && word_short) |=> $stable(input_reg) && $stable(conv_reg)
		&& $stable(shutdown_reg) && !o_word_taken)
		else $error("incomplete word changed state");

	reset_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
		$fell(i_reset) |-> (input_reg == 12'h000) &&
		(conv_reg == 12'h000) && !o_shutdown)
		else $error("registers not cleared by reset");

	bipolar_view_a: assert property (@(posedge i_clk) disable iff (i_reset)
		o_bipolar_code == {~o_unipolar_code[11],
		o_unipolar_code[10:0]})
		else $error("offset binary view wrong");

	load_word_c: cover property (@(posedge i_clk) disable iff (i_reset)
		word_done && cmd[1:0] == 2'h0);
	enter_off_c: cover property (@(posedge i_clk) disable iff (i_reset)
		$rose(o_shutdown));
	short_word_c: cover property (@(posedge i_clk) disable iff (i_reset)
		word_short);

endmodule // dac_serial_load_port

// ===== tb/serial_host_model.sv
// Purpose: host side of the three-wire converter load port
// Assumes: link period 160 ns, unrelated in phase to i_clk
// Notes:   serial clock idles low; noise() toggles it with select left high
module serial_host_model (
	// serial pins
	output logic o_select_n,
	output logic o_sclk,
	output logic o_sdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// link timing
	// half of a 160 ns period keeps the link well under its ceiling
	localparam time HALF  = 80ns;
	localparam time SETUP = 100ns;

	initial begin
		o_select_n = 1'b1;
		o_sclk     = 1'b0;
		o_sdata    = 1'b0;
	end

	// ============================================================
	// frames
	// sends w[n-1:0] msb first; pause > 0 idles the clock after that bit
	task automatic send(input logic [31:0] w, input int n, input int pause);
		logic [31:0] v;
		v = w;
		if (n == 16)
			v[0] = 1'b0;
		#7ns;
		// only this device's select is lowered; clock and data are shared
		o_select_n = 1'b0;
		#SETUP;
		for (int i = n - 1; i >= 0; i--) begin
			o_sdata = v[i];
			#HALF;
			o_sclk = 1'b1;
			#HALF;
			o_sclk = 1'b0;
			if (pause != 0 && i == n - pause)
				#400ns;
		end
		#HALF;
		o_select_n = 1'b1;
		// released data line must not keep its last level
		o_sdata = ~o_sdata;
		#SETUP;
	endtask

	// clock and data activity with select left high
	task automatic noise(input int n);
		for (int i = 0; i < n; i++) begin
			o_sdata = i[0];
			#HALF;
			o_sclk = 1'b1;
			#HALF;
			o_sclk = 1'b0;
		end
		o_sdata = ~o_sdata;
	endtask
endmodule // serial_host_model

// ===== tb/dac_serial_load_port_test.sv
// Purpose: self-checking bench of the converter load port
// Assumes: i_clk 50 MHz, reset and enable driven at the falling edge
// Notes:   outputs judged about fifteen cycles after select rises
module dac_serial_load_port_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        i_clk;
	logic        i_reset;
	logic        i_ce;
	logic        select_n;
	logic        sclk;
	logic        sdata;
	logic [11:0] input_code;
	logic [11:0] uni_code;
	logic [11:0] bi_code;
	logic        shutdown;
	logic        word_taken;
	int          err_total;
	int          checked;
	int          pulses;

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
	$display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end

	serial_host_model host (
		.o_select_n(select_n),
		.o_sclk    (sclk),
		.o_sdata   (sdata)
	);

	dac_serial_load_port uut (
		.i_clk          (i_clk),
		.i_reset        (i_reset),
		.i_ce           (i_ce),
		.i_select_n     (select_n),
		.i_sclk         (sclk),
		.i_sdata        (sdata),
		.o_input_code   (input_code),
		.o_unipolar_code(uni_code),
		.o_bipolar_code (bi_code),
		.o_shutdown     (shutdown),
		.o_word_taken   (word_taken)
	);

	// ============================================================
	// clock, pulse monitor, closing
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		if (word_taken === 1'b1)
			pulses++;
	end

	task end_of_test;
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ============================================================
	// shared steps
	task xfer(input logic [31:0] w, input int n, input int pause);
		host.send(w, n, pause);
		repeat (10) @(negedge i_clk);
	endtask

	// bipolar view is the converter code with its msb turned over
	task expect_regs(input logic [11:0] in_e, input logic [11:0] cv_e,
			input logic sd_e, input int p_e);
		`CHK(input_code, in_e)
		`CHK(uni_code, cv_e)
		`CHK(bi_code, cv_e ^ 12'h800)
		`CHK(shutdown, sd_e)
		`CHK(pulses, p_e)
		pulses = 0;
	endtask

	task do_reset;
		@(negedge i_clk);
		i_reset = 1'b1;
		repeat (3) @(negedge i_clk);
		i_reset = 1'b0;
		pulses = 0;
		@(negedge i_clk);
	endtask

	// ============================================================
	// scenarios
	task t_load_both;
		xfer({3'b000, 12'habc, 1'b0}, 16, 0);
		expect_regs(12'habc, 12'habc, 1'b0, 1);
		xfer({3'b100, 12'h5a3, 1'b0}, 16, 0);
		expect_regs(12'h5a3, 12'h5a3, 1'b0, 1);
		$display("test load_both done");
	endtask

	task t_input_only;
		xfer({3'b001, 12'h123, 1'b0}, 16, 0);
		expect_regs(12'h123, 12'h5a3, 1'b0, 1);
		xfer({3'b101, 12'hfff, 1'b0}, 16, 0);
		expect_regs(12'hfff, 12'h5a3, 1'b0, 1);
		$display("test input_only done");
	endtask

	task t_shutdown;
		xfer({3'b111, 12'h000, 1'b0}, 16, 0);
		expect_regs(12'hfff, 12'h5a3, 1'b1, 1);
		xfer({3'b001, 12'h000, 1'b0}, 16, 0);
		expect_regs(12'h000, 12'h5a3, 1'b1, 1);
		xfer({3'b010, 12'h777, 1'b0}, 16, 0);
		expect_regs(12'h000, 12'h000, 1'b0, 1);
		xfer({3'b001, 12'hfff, 1'b0}, 16, 0);
		xfer({3'b110, 12'h000, 1'b0}, 16, 0);
		expect_regs(12'hfff, 12'hfff, 1'b0, 2);
		$display("test shutdown done");
	endtask

	task t_idle_and_ignored;
		xfer({3'b011, 12'h3c3, 1'b0}, 16, 0);
		expect_regs(12'hfff, 12'hfff, 1'b0, 1);
		host.noise(16);
		repeat (10) @(negedge i_clk);
		expect_regs(12'hfff, 12'hfff, 1'b0, 0);
		$display("test idle_and_ignored done");
	endtask

	task t_word_length;
		xfer({17'h0, 3'b000, 12'h123}, 15, 0);
		expect_regs(12'hfff, 12'hfff, 1'b0, 0);
		xfer({24'h0, 8'h0f}, 8, 0);
		expect_regs(12'hfff, 12'hfff, 1'b0, 0);
		// extra leading bits slide out; the last sixteen count
		xfer({12'h0, 4'ha, 3'b000, 12'h7e1, 1'b0}, 20, 0);
		expect_regs(12'h7e1, 12'h7e1, 1'b0, 1);
		xfer({3'b000, 12'h2c4, 1'b0}, 16, 8);
		expect_regs(12'h2c4, 12'h2c4, 1'b0, 1);
		$display("test word_length done");
	endtask

	// with the enable low a whole frame must leave no trace
	task t_freeze_midscale;
		i_ce = 1'b0;
		xfer({3'b000, 12'habc, 1'b0}, 16, 0);
		i_ce = 1'b1;
		repeat (4) @(negedge i_clk);
		expect_regs(12'h2c4, 12'h2c4, 1'b0, 0);
		// msb-only code is the bipolar zero
		xfer({3'b000, 12'h800, 1'b0}, 16, 0);
		expect_regs(12'h800, 12'h800, 1'b0, 1);
		$display("test freeze_midscale done");
	endtask

	// ============================================================
	// main sequence and watchdog
	initial begin
		err_total = 0;
		checked   = 0;
		pulses    = 0;
		i_reset   = 1'b1;
		i_ce      = 1'b1;
		repeat (3) @(negedge i_clk);
		i_reset = 1'b0;
		@(negedge i_clk);
		expect_regs(12'h000, 12'h000, 1'b0, 0);
		t_load_both();
		t_input_only();
		t_shutdown();
		t_idle_and_ignored();
		t_word_length();
		t_freeze_midscale();
		do_reset();
		expect_regs(12'h000, 12'h000, 1'b0, 0);
		$display("test reset done");
		end_of_test();
	end

	// the whole run needs well under 100 us
	initial begin
		#500us;
		err_total++;
		$display("watchdog expired");
		end_of_test();
	end
endmodule // dac_serial_load_port_test
